// [core/sea_pkg.sv]
package sea_pkg;

   // ------------------------------------------------------------
   // Register map on the APB side (byte addresses).
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h0A0;
   localparam logic [11:0] ADDR_RDATA = 12'h0A4;
   localparam logic [11:0] ADDR_PHY23 = 12'h0A8;
   localparam logic [11:0] ADDR_BUFCTL = 12'h0AC;
   localparam logic [11:0] ADDR_PIPE2_BASE = 12'h0B0;
   localparam logic [11:0] ADDR_STEP = 12'h004;

   // Control register fields.
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_BUSY_BIT = 2;
   localparam int CTRL_DONE_BIT = 4;
   localparam int CTRL_ADDR_LSB = 8;
   localparam int CTRL_WDATA_LSB = 16;

   // ------------------------------------------------------------
   // Memory layout: byte offsets, word address is offset / 2.
   // ------------------------------------------------------------
   localparam logic [8:0] BYTE_SIG = 9'h000;
   localparam logic [8:0] BYTE_PHY23 = 9'h014;
   localparam logic [8:0] BYTE_BUFCTL = 9'h01C;
   localparam logic [8:0] BYTE_PIPE2_P1 = 9'h022;
   localparam logic [8:0] BYTE_LAST = 9'h02A;
   localparam logic [7:0] WORD_SIG = BYTE_SIG[8:1];
   localparam logic [7:0] WORD_PHY23 = BYTE_PHY23[8:1];
   localparam logic [7:0] WORD_BUFCTL = BYTE_BUFCTL[8:1];
   localparam logic [7:0] WORD_PIPE2_P0 = BYTE_PIPE2_P1[8:1] - 8'h01;
   localparam logic [7:0] WORD_LAST = BYTE_LAST[8:1];
   localparam int NUM_PORTS = 6;

   // Serial memory opcodes and frame lengths.
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [5:0] FRAME_BITS = 6'h20;
   localparam logic [5:0] WREN_BITS = 6'h08;

   // ------------------------------------------------------------
   // State encodings, Gray along the usual path.
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEA_WAIT = 3'h0,
      SEA_SIG = 3'h1,
      SEA_LOAD = 3'h3,
      SEA_DONE = 3'h2,
      SEA_SW = 3'h6
   } sea_sys_e;

   typedef enum logic [1:0] {
      SEA_L_IDLE = 2'h0,
      SEA_L_WREN = 2'h1,
      SEA_L_GAP = 2'h3,
      SEA_L_MAIN = 2'h2
   } sea_link_e;

endpackage

// [core/sea_spi_link.sv]
`timescale 1ns/100ps
module sea_spi_link
   import sea_pkg::*;
#(
   parameter int DIV_HALF = 4
) (
   input wire logic clk_link, // Link clock.
   input wire logic srst, // System reset, resynchronised here.
   input wire logic req_tgl, // Request toggle from system side.
   input wire logic req_write, // One for a word write.
   input wire logic [7:0] req_addr, // Word address.
   input wire logic [15:0] req_wdata, // Word to write.
   output logic ack_tgl, // Completion toggle.
   output logic [15:0] rsp_rdata, // Word read, stable after ack.
   output logic rom_serial_clock, // Serial clock to memory.
   output logic rom_select_n, // Chip select, active low.
   output logic rom_serial_out, // Data to memory.
   input wire logic rom_serial_in // Data from memory.
);

   localparam int CW = (DIV_HALF > 1) ? $clog2(DIV_HALF) : 1;

   initial begin
      if (DIV_HALF < 3) begin
         $error("DIV_HALF must be at least 3 to sample after sync.");
      end
   end

   logic rst_q1, rst_q2, req_q1, req_q2, req_q3, miso_q1, miso_q2;
   logic [CW-1:0] cnt_q;
   logic [5:0] bits_q;
   logic [31:0] shift_q;
   logic [15:0] rx_q;
   sea_link_e state_q;
   logic wrap;

   // ------------------------------------------------------------
   // Synchronisers into the link domain.
   // ------------------------------------------------------------
   always_ff @(posedge clk_link) begin
      rst_q1 <= srst;
      rst_q2 <= rst_q1;
   end

   // The request fields are held by the system side while busy.
   always_ff @(posedge clk_link) begin
      if (rst_q2) begin
         req_q1 <= 1'b0;
         req_q2 <= 1'b0;
         req_q3 <= 1'b0;
         miso_q1 <= 1'b0;
         miso_q2 <= 1'b0;
      end else begin
         req_q1 <= req_tgl;
         req_q2 <= req_q1;
         req_q3 <= req_q2;
         miso_q1 <= rom_serial_in;
         miso_q2 <= miso_q1;
      end
   end

   assign wrap = (cnt_q == CW'(DIV_HALF - 1));
   assign rom_serial_out = shift_q[31];

   // ------------------------------------------------------------
   // Frame engine: mode 0, data changes while the clock is low.
   // Input is sampled at the falling edge through the synchroniser,
   // so the value seen was on the line mid high phase.
   // ------------------------------------------------------------
   always_ff @(posedge clk_link) begin
      if (rst_q2) begin
         state_q <= SEA_L_IDLE;
         cnt_q <= '0;
         bits_q <= '0;
         shift_q <= '0;
         rx_q <= '0;
         rsp_rdata <= '0;
         ack_tgl <= 1'b0;
         rom_serial_clock <= 1'b0;
         rom_select_n <= 1'b1;
      end else begin
         case (state_q)
            SEA_L_IDLE: begin
               cnt_q <= '0;
               if (req_q2 ^ req_q3) begin
                  rom_select_n <= 1'b0;
                  if (req_write) begin
                     shift_q <= {OP_WREN, 24'h000000};
                     bits_q <= WREN_BITS;
                     state_q <= SEA_L_WREN;
                  end else begin
                     shift_q <= {OP_READ, req_addr, 16'h0000};
                     bits_q <= FRAME_BITS;
                     state_q <= SEA_L_MAIN;
                  end
               end
            end
            SEA_L_WREN, SEA_L_MAIN: begin
               cnt_q <= wrap ? '0 : cnt_q + 1'b1;
               if (wrap && !rom_serial_clock) begin
                  rom_serial_clock <= 1'b1;
               end else if (wrap) begin
                  rom_serial_clock <= 1'b0;
                  rx_q <= {rx_q[14:0], miso_q2};
                  shift_q <= {shift_q[30:0], 1'b0};
                  bits_q <= bits_q - 1'b1;
                  if (bits_q == 6'h01) begin
                     rom_select_n <= 1'b1;
                     if (state_q == SEA_L_WREN) begin
                        state_q <= SEA_L_GAP;
                     end else begin
                        rsp_rdata <= {rx_q[14:0], miso_q2};
                        ack_tgl <= ~ack_tgl;
                        state_q <= SEA_L_IDLE;
                     end
                  end
               end
            end
            SEA_L_GAP: begin
               cnt_q <= wrap ? '0 : cnt_q + 1'b1;
               if (wrap) begin
                  rom_select_n <= 1'b0;
                  shift_q <= {OP_WRITE, req_addr, req_wdata};
                  bits_q <= FRAME_BITS;
                  state_q <= SEA_L_MAIN;
               end
            end
            default: begin
               state_q <= SEA_L_IDLE;
               rom_select_n <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks on the link pins and the read frame.
   // ------------------------------------------------------------
   a_clk_in_frame: assert property (
      @(posedge clk_link) disable iff (rst_q2)
      rom_serial_clock |-> !rom_select_n)
      else $error("Serial clock high outside a selected frame.");

   a_read_addr_sent: assert property (
      @(posedge clk_link) disable iff (rst_q2)
      (state_q == SEA_L_IDLE && (req_q2 ^ req_q3) && !req_write)
      |=> shift_q[23:16] == $past(req_addr) && bits_q == FRAME_BITS)
      else $error("Read frame does not carry the word address.");

endmodule

// [core/sea_autoload.sv]
`timescale 1ns/100ps
module sea_autoload
   import sea_pkg::*;
#(
   parameter logic [15:0] SIGNATURE = 16'hA55A, // Arbitrary value.
   parameter logic [15:0] PHY23_RESET = 16'h0000,
   parameter logic [15:0] BUFCTL_RESET = 16'h0000,
   parameter logic [15:0] PIPE2_RESET = 16'h0000,
   parameter int DIV_HALF = 4
) (
   input wire logic clk_sys, // System clock, 125 MHz.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic clk_link, // Serial link clock.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic fundamental_reset_n, // Pin, active low.
   output logic rom_serial_clock, // Serial clock to memory.
   output logic rom_select_n, // Chip select, active low.
   output logic rom_serial_out, // Data to memory.
   input wire logic rom_serial_in, // Data from memory.
   output logic load_done, // Load sequence finished.
   output logic [15:0] phy_param23, // PHY parameter 2/3, all ports.
   output logic [7:0] buffer_ctrl, // Buffer control, all ports.
   output logic [7:0] pipe_control_five_hi, // Pipe five bits 23:16.
   output logic [NUM_PORTS*16-1:0] pipe_control_two // Per-port words.
);

   sea_sys_e state_q;
   logic frst_q1, frst_q2, ack_q1, ack_q2, ack_q3, ack_new;
   logic req_tgl_q, busy_q, done_q, cmd_write_q, ack_tgl, sig_ok;
   logic [7:0] cmd_addr_q, word_q;
   logic [15:0] cmd_wdata_q, rd_q, phy23_q, bufctl_q, rsp_rdata;
   logic [15:0] pipe2_q [NUM_PORTS];
   logic issue, issue_write, sw_start, apb_wr, apb_setup, mapped;
   logic [7:0] issue_addr;
   logic [15:0] issue_wdata;
   logic [31:0] rd_mux;

   // ------------------------------------------------------------
   // Pin and cross-domain synchronisers.
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         frst_q1 <= 1'b0;
         frst_q2 <= 1'b0;
         ack_q1 <= 1'b0;
         ack_q2 <= 1'b0;
         ack_q3 <= 1'b0;
      end else begin
         frst_q1 <= fundamental_reset_n;
         frst_q2 <= frst_q1;
         ack_q1 <= ack_tgl;
         ack_q2 <= ack_q1;
         ack_q3 <= ack_q2;
      end
   end

   assign ack_new = ack_q2 ^ ack_q3;
   assign sig_ok = (rsp_rdata == SIGNATURE);
   assign apb_wr = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   // A start is honoured only when idle; early starts are dropped.
   assign sw_start = apb_wr && paddr == ADDR_CTRL
      && pwdata[CTRL_START_BIT] && state_q == SEA_DONE && !busy_q;

   // ------------------------------------------------------------
   // Word requests towards the link engine.
   // ------------------------------------------------------------
   always_comb begin
      issue = 1'b0;
      issue_addr = WORD_SIG;
      issue_write = 1'b0;
      issue_wdata = 16'h0000;
      case (state_q)
         SEA_WAIT: begin
            issue = frst_q2 && !busy_q;
            issue_addr = WORD_SIG;
         end
         SEA_SIG: begin
            issue = frst_q2 && ack_new && sig_ok;
            issue_addr = WORD_SIG + 8'h01;
         end
         SEA_LOAD: begin
            issue = frst_q2 && ack_new && word_q != WORD_LAST;
            issue_addr = word_q + 8'h01;
         end
         SEA_DONE: begin
            issue = frst_q2 && sw_start;
            issue_addr = pwdata[CTRL_ADDR_LSB +: 8];
            issue_write = pwdata[CTRL_WRITE_BIT];
            issue_wdata = pwdata[CTRL_WDATA_LSB +: 16];
         end
         default: begin
            issue = 1'b0;
         end
      endcase
   end

   // Command fields stay still while busy; the link reads them then.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         req_tgl_q <= 1'b0;
         busy_q <= 1'b0;
         cmd_addr_q <= '0;
         cmd_write_q <= 1'b0;
         cmd_wdata_q <= '0;
      end else begin
         busy_q <= issue || (busy_q && !ack_new);
         if (issue) begin
            req_tgl_q <= ~req_tgl_q;
            cmd_addr_q <= issue_addr;
            cmd_write_q <= issue_write;
            cmd_wdata_q <= issue_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer. A fundamental reset aborts and restarts it.
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= SEA_WAIT;
         word_q <= '0;
         done_q <= 1'b0;
      end else if (!frst_q2) begin
         state_q <= SEA_WAIT;
         done_q <= 1'b0;
      end else begin
         case (state_q)
            SEA_WAIT: begin
               if (issue) begin
                  state_q <= SEA_SIG;
               end
            end
            SEA_SIG: begin
               if (ack_new && sig_ok) begin
                  word_q <= issue_addr;
                  state_q <= SEA_LOAD;
               end else if (ack_new) begin
                  state_q <= SEA_DONE;
                  done_q <= 1'b1;
               end
            end
            SEA_LOAD: begin
               if (ack_new && word_q == WORD_LAST) begin
                  state_q <= SEA_DONE;
                  done_q <= 1'b1;
               end else if (ack_new) begin
                  word_q <= issue_addr;
               end
            end
            SEA_DONE: begin
               if (issue) begin
                  state_q <= SEA_SW;
               end
            end
            SEA_SW: begin
               if (ack_new) begin
                  state_q <= SEA_DONE;
               end
            end
            default: begin
               state_q <= SEA_WAIT;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Loaded parameters; back to defaults while the pin holds reset.
   // Words outside this block's fields are fetched and dropped.
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst || !frst_q2) begin
         phy23_q <= PHY23_RESET;
         bufctl_q <= BUFCTL_RESET;
      end else if (state_q == SEA_LOAD && ack_new) begin
         if (word_q == WORD_PHY23) begin
            phy23_q <= rsp_rdata;
         end
         if (word_q == WORD_BUFCTL) begin
            bufctl_q <= rsp_rdata;
         end
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         always_ff @(posedge clk_sys) begin
            if (srst || !frst_q2) begin
               pipe2_q[p] <= PIPE2_RESET;
            end else if (state_q == SEA_LOAD && ack_new
                         && word_q == WORD_PIPE2_P0 + 8'(p)) begin
               pipe2_q[p] <= rsp_rdata;
            end
         end
         assign pipe_control_two[p*16 +: 16] = pipe2_q[p];
      end
   endgenerate

   // Last word seen, kept for software reads.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_q <= '0;
      end else if (ack_new) begin
         rd_q <= rsp_rdata;
      end
   end

   assign load_done = done_q;
   assign phy_param23 = phy23_q;
   assign buffer_ctrl = bufctl_q[15:8];
   assign pipe_control_five_hi = bufctl_q[7:0];

   // ------------------------------------------------------------
   // APB slave: zero wait, read data captured in the setup cycle.
   // ------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         ADDR_CTRL: begin
            rd_mux[CTRL_BUSY_BIT] = busy_q;
            rd_mux[CTRL_DONE_BIT] = done_q;
            rd_mux[CTRL_WRITE_BIT] = cmd_write_q;
            rd_mux[CTRL_ADDR_LSB +: 8] = cmd_addr_q;
            rd_mux[CTRL_WDATA_LSB +: 16] = cmd_wdata_q;
         end
         ADDR_RDATA: rd_mux[15:0] = rd_q;
         ADDR_PHY23: rd_mux[15:0] = phy23_q;
         ADDR_BUFCTL: rd_mux[15:0] = bufctl_q;
         default: begin
            mapped = 1'b0;
            for (int i = 0; i < NUM_PORTS; i++) begin
               if (paddr == ADDR_PIPE2_BASE + 12'(i) * ADDR_STEP) begin
                  mapped = 1'b1;
                  rd_mux[15:0] = pipe2_q[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= !mapped;
      end
   end

   assign pready = 1'b1;

   // ------------------------------------------------------------
   // Serial link engine on its own clock.
   // ------------------------------------------------------------
   sea_spi_link #(
      .DIV_HALF(DIV_HALF)
   ) u_link (
      .clk_link(clk_link),
      .srst(srst),
      .req_tgl(req_tgl_q),
      .req_write(cmd_write_q),
      .req_addr(cmd_addr_q),
      .req_wdata(cmd_wdata_q),
      .ack_tgl(ack_tgl),
      .rsp_rdata(rsp_rdata),
      .rom_serial_clock(rom_serial_clock),
      .rom_select_n(rom_select_n),
      .rom_serial_out(rom_serial_out),
      .rom_serial_in(rom_serial_in)
   );

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   a_fetch_on_release: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_WAIT && frst_q2 && !busy_q)
      |=> state_q == SEA_SIG && busy_q && cmd_addr_q == WORD_SIG)
      else $error("Fetch did not start after reset release.");

   a_sig_word_zero: assert property (
      @(posedge clk_sys) disable iff (srst)
      state_q == SEA_SIG |-> cmd_addr_q == WORD_SIG && !cmd_write_q)
      else $error("Signature read not at word zero.");

   a_auto_continue: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_SIG && ack_new && sig_ok && frst_q2)
      |=> state_q == SEA_LOAD && busy_q && cmd_addr_q == WORD_SIG + 8'h01)
      else $error("Load did not follow a good signature.");

   a_addr_step: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_LOAD && ack_new && frst_q2 && word_q != WORD_LAST)
      |=> word_q == $past(word_q) + 8'h01 && cmd_addr_q == word_q)
      else $error("Load address did not step by one.");

   a_done_flag: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_LOAD && ack_new && frst_q2 && word_q == WORD_LAST)
      |=> load_done ##1 (load_done || !frst_q2))
      else $error("Done flag not set after last word.");

   a_phy23_store: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_LOAD && ack_new && frst_q2 && word_q == WORD_PHY23)
      |=> phy_param23 == $past(rsp_rdata))
      else $error("PHY parameter word not applied.");

   a_bufctl_split: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_LOAD && ack_new && frst_q2 && word_q == WORD_BUFCTL)
      |=> {buffer_ctrl, pipe_control_five_hi} == $past(rsp_rdata))
      else $error("Buffer control word split wrongly.");

   a_pipe2_port1: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_LOAD && ack_new && frst_q2
       && word_q == BYTE_PIPE2_P1[8:1])
      |=> pipe_control_two[31:16] == $past(rsp_rdata))
      else $error("Port 1 pipe word not applied.");

   a_bad_sig_done: assert property (
      @(posedge clk_sys) disable iff (srst)
      (state_q == SEA_SIG && ack_new && !sig_ok && frst_q2)
      |=> load_done && !busy_q && phy_param23 == PHY23_RESET)
      else $error("Bad signature did not finish with defaults.");

   a_sw_launch: assert property (
      @(posedge clk_sys) disable iff (srst)
      (sw_start && frst_q2) |=> state_q == SEA_SW && busy_q
      && cmd_addr_q == $past(pwdata[CTRL_ADDR_LSB +: 8]))
      else $error("Software access not launched.");

   c_full_load: cover property (@(posedge clk_sys) disable iff (srst)
      state_q == SEA_LOAD && ack_new && word_q == WORD_LAST);
   c_bad_sig: cover property (@(posedge clk_sys) disable iff (srst)
      state_q == SEA_SIG && ack_new && !sig_ok);
   c_sw_write: cover property (@(posedge clk_sys) disable iff (srst)
      sw_start && pwdata[CTRL_WRITE_BIT]);
   c_sw_read: cover property (@(posedge clk_sys) disable iff (srst)
      state_q == SEA_SW && ack_new && !cmd_write_q);

endmodule

// [sim/sea_rom_model.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------
// Serial memory model, clock mode 0.
// ----------------------------------------------------------
module sea_rom_model #(
   parameter logic [15:0] SIG = 16'h3C5A // Arbitrary value.
) (
   input wire logic sck, // Serial clock.
   input wire logic cs_n, // Select, active low.
   input wire logic si, // Data into the memory.
   output logic so // Data out of the memory.
);
   logic [15:0] mem [256];
   logic [15:0] rd;
   logic [31:0] sh;
   logic [5:0] cnt;
   logic wel;
   // Words 1 to 255 hold a pattern the bench can predict; word 0 holds SIG.
   initial begin
      for (int i = 1; i < 256; i++) begin
         mem[i] = {8'(i) ^ 8'hA5, 8'(i)};
      end
      mem[0] = SIG;
      wel = 1'b0;
      so = 1'b0;
   end
   // Bits enter on the rising clock; a frame is judged when select rises.
   always @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         if (cnt == 6'd8 && sh[7:0] == 8'h06) begin
            wel <= 1'b1;
         end
         if (cnt == 6'd32 && sh[31:24] == 8'h02 && wel) begin
            mem[sh[23:16]] <= sh[15:0];
            wel <= 1'b0;
         end
         cnt <= '0;
      end else begin
         sh <= {sh[30:0], si};
         cnt <= cnt + 6'd1;
      end
   end
   // Data leaves on the falling clock; a released line flips so that a
   // stale value is never mistaken for data.
   always @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so <= ~so;
      end else if (cnt == 6'd16) begin
         rd = mem[sh[7:0]];
         so <= rd[15];
      end else if (cnt > 6'd16 && cnt < 6'd32) begin
         so <= rd[31-cnt];
      end
   end
endmodule

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import sea_pkg::*;
   localparam logic [15:0] SIG = 16'h3C5A; // Arbitrary value.
   logic clk_sys = 0, clk_link = 0, srst = 1, psel = 0, penable = 0;
   logic pwrite = 0, fundamental_reset_n = 0, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, rom_serial_clock, rom_select_n, rom_serial_out;
   logic rom_serial_in, load_done;
   logic [15:0] phy_param23;
   logic [7:0] buffer_ctrl, pipe_control_five_hi;
   logic [95:0] pipe_control_two;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   // ----------------------------------------------------------
   // Clocks, design and memory.
   // ----------------------------------------------------------
   // The link clock starts off phase so the crossing is exercised.
   always #4 clk_sys = ~clk_sys;
   initial begin
      #13;
      forever #40 clk_link = ~clk_link;
   end
   sea_autoload #(.SIGNATURE(SIG), .DIV_HALF(3)) sea_autoload_i (.clk_sys,
      .srst, .clk_link, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fundamental_reset_n, .rom_serial_clock,
      .rom_select_n, .rom_serial_out, .rom_serial_in, .load_done,
      .phy_param23, .buffer_ctrl, .pipe_control_five_hi, .pipe_control_two);
   sea_rom_model #(.SIG(SIG)) sea_rom_model_i (.sck(rom_serial_clock),
      .cs_n(rom_select_n), .si(rom_serial_out), .so(rom_serial_in));
   function automatic logic [15:0] pat(input logic [7:0] i);
      return {i ^ 8'hA5, i};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("wrong value at %0t: %h expected %h", $time, s, x);
      end
   endtask
   // One APB transfer; result lands in r and e at the completing edge.
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // Busy must read clear before software starts another access.
   task automatic poll();
      do apb(0, ADDR_CTRL, '0); while (r[CTRL_BUSY_BIT] !== 1'b0);
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A hang counts against the run.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 95000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------
   // Test sequence.
   // ----------------------------------------------------------
   initial begin
      repeat (40) @(posedge clk_sys);
      srst <= 0;
      repeat (200) @(posedge clk_sys);
      chk(load_done, 0);
      chk(rom_select_n, 1);
      fundamental_reset_n <= 1;
      while (load_done !== 1'b1) @(posedge clk_sys);
      apb(0, ADDR_CTRL, '0);
      chk(r & 32'h14, 32'h10);
      chk(phy_param23, pat(8'h0A));
      chk({buffer_ctrl, pipe_control_five_hi}, pat(8'h0E));
      apb(0, ADDR_PHY23, '0);
      chk(r, pat(8'h0A));
      apb(0, ADDR_BUFCTL, '0);
      chk(r, pat(8'h0E));
      for (int p = 0; p < 6; p++) begin
         chk(pipe_control_two[16*p+:16], pat(8'h10 + 8'(p)));
         apb(0, ADDR_PIPE2_BASE + 12'(4 * p), '0);
         chk(r, pat(8'h10 + 8'(p)));
      end
      apb(1, 12'h0C8, 32'hFFFF_FFFF);
      chk(e, 1);
      // Word write then read back through the sequencer.
      apb(1, ADDR_CTRL, {16'hBEEF, 8'h30, 8'h03});
      poll();
      chk(r, 32'hBEEF_3012);
      apb(1, ADDR_CTRL, {16'h0000, 8'h30, 8'h01});
      poll();
      apb(0, ADDR_RDATA, '0);
      chk(r, 32'h0000_BEEF);
      // Spoil the signature and reload: defaults stay, done still sets.
      apb(1, ADDR_CTRL, {16'h0000, 8'h00, 8'h03});
      poll();
      fundamental_reset_n <= 0;
      repeat (20) @(posedge clk_sys);
      chk(load_done, 0);
      fundamental_reset_n <= 1;
      while (load_done !== 1'b1) @(posedge clk_sys);
      chk(phy_param23, 0);
      chk(pipe_control_two[31:0], 0);
      apb(0, ADDR_CTRL, '0);
      chk(r[CTRL_DONE_BIT], 1);
      tally_and_finish();
   end
endmodule
